// ---- core/lpzq_core.sv ----
// Purpose: power-down entry/exit and impedance calibration command
//          handling inside a low-power DDR memory device.
// Assumes: link clock, clock enable, chip select and command pins are
//          asynchronous to mclk_i and are resynchronised here.
// Notes:   the controller keeps its own timing; this block only reacts.
//
// Notes on behaviour
// - calibration accepted only with all banks precharged
// - strapped reference pin: ignore calibration commands
// - enter power-down: enable low, select high
// - power-down classed idle or active at entry
// - power-down disables buffers except clock, enable
// - no refresh while powered down
// - leave power-down when enable sampled high
module lpzq_core
  import lpzq_pkg::*;
#(
  parameter int         INIT_CAL_NS  = 1000, // initial calibration period
  parameter int         LONG_CAL_NS  = 360,  // long calibration period
  parameter int         SHORT_CAL_NS = 90,   // short calibration period
  parameter logic [7:0] OP_INIT    = 8'h01, // calibration opcodes
  parameter logic [7:0] OP_LONG    = 8'h02,
  parameter logic [7:0] OP_SHORT   = 8'h03,
  parameter logic [7:0] OP_RESET   = 8'h04
) (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       link_ck_i,     // controller clock pin
  input  wire lpzq_pins_t pins_i,        // enable, select, command
  input  wire logic       ref_tied_i,    // reference pin tied to supply
  input  wire logic       banks_open_i,  // any row open, same clock
  output lpzq_stat_t      stat_o
);

  // least times round up to whole core cycles
  localparam int INIT_CYC  = (INIT_CAL_NS * CLK_MHZ + 999) / 1000;
  localparam int LONG_CYC  = (LONG_CAL_NS * CLK_MHZ + 999) / 1000;
  localparam int SHORT_CYC = (SHORT_CAL_NS * CLK_MHZ + 999) / 1000;

  // period length in core cycles for one calibration kind
  function automatic logic [CNT_W-1:0] cal_len(input lpzq_cal_t k);
    unique case (k)
      CAL_INIT:  cal_len = CNT_W'(INIT_CYC);
      CAL_LONG:  cal_len = CNT_W'(LONG_CYC);
      CAL_SHORT: cal_len = CNT_W'(SHORT_CYC);
      CAL_NONE:  cal_len = CNT_RST;
    endcase
  endfunction : cal_len

  logic [SYNC_W-1:0] sync_w;
  logic              ck_s;
  logic              ref_tied_s;
  lpzq_pins_t        pins_s;
  lpzq_state_t       st_q;
  lpzq_state_t       st_d;

  lpzq_sync #(
    .W (SYNC_W)
  ) u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i ({link_ck_i, ref_tied_i, pins_i}),
    .sync_o  (sync_w)
  );

  assign ck_s      = sync_w[SYNC_W-1];
  assign ref_tied_s = sync_w[SYNC_W-2];
  assign pins_s    = sync_w[SYNC_W-3:0];

  // next-state logic: edges of the sampled link clock act as its edges
  always_comb begin
    logic       rise;
    logic       fall;
    logic [7:0] ma;
    logic [7:0] op;
    lpzq_cal_t  kind;
    rise = 1'b0;
    fall = 1'b0;
    ma   = 8'h00;
    op   = 8'h00;
    kind = CAL_NONE;
    st_d = st_q;
    rise = ck_s && !st_q.ck_prev;
    fall = !ck_s && st_q.ck_prev;
    st_d.ck_prev          = ck_s;
    st_d.stat.cal_done    = 1'b0;
    st_d.stat.cal_ignored = 1'b0;

    // strap followed every cycle: a one-shot capture would take the
    // synchroniser's reset zero, not the pin
    st_d.tied       = ref_tied_s;
    st_d.tied_valid = 1'b1;

    // calibration timer; a running one ends on its own count
    if (st_q.stat.cal_kind != CAL_NONE) begin
      if (st_q.cal_cnt <= CNT_W'(1)) begin
        st_d.stat.cal_kind   = CAL_NONE;
        st_d.stat.cal_done   = 1'b1;
        st_d.stat.imp_default = 1'b0;
        st_d.cal_cnt         = CNT_RST;
      end else begin
        st_d.cal_cnt = st_q.cal_cnt - CNT_W'(1);
      end
    end

    if (rise) begin
      st_d.cke_prev = pins_s.cke;
      st_d.wr_half  = 1'b0;
      if (st_q.stat.pd_mode != PD_NONE) begin
        if (pins_s.cke) begin
          st_d.stat.pd_mode      = PD_NONE;
          st_d.stat.io_buf_en    = 1'b1;
          st_d.stat.refresh_hold = 1'b0;
        end
      end else if (st_q.cke_prev && !pins_s.cke && pins_s.cs_n) begin
        st_d.stat.pd_mode = banks_open_i ? PD_ACTIVE : PD_IDLE;
        st_d.stat.io_buf_en    = 1'b0;
        st_d.stat.refresh_hold = 1'b1;
      end else if (pins_s.cke && !pins_s.cs_n
                   && pins_s.ca[3:0] == MODE_WR_CODE) begin
        st_d.wr_half  = 1'b1;  // wait for second half on falling edge
        st_d.ca_rise  = pins_s.ca;
      end
    end

    // second half of a mode write completes the command
    if (fall && st_q.wr_half && st_q.stat.pd_mode == PD_NONE) begin
      st_d.wr_half  = 1'b0;
      ma = {pins_s.ca[1:0], st_q.ca_rise[9:4]};
      op = pins_s.ca[9:2];
      if (ma == CAL_MR_ADDR) begin
        if (op == OP_INIT) begin
          kind = CAL_INIT;
        end else if (op == OP_LONG) begin
          kind = CAL_LONG;
        end else if (op == OP_SHORT) begin
          kind = CAL_SHORT;
        end
        if (st_q.tied || !st_q.tied_valid) begin
          st_d.stat.cal_ignored = 1'b1;
        end else if (banks_open_i || st_q.stat.cal_kind != CAL_NONE) begin
          st_d.stat.cal_ignored = 1'b1;
        end else if (op == OP_RESET) begin
          // reset takes effect with no period
          st_d.stat.imp_default = 1'b1;
        end else if (kind != CAL_NONE) begin
          st_d.stat.cal_kind = kind;
          st_d.cal_cnt       = cal_len(kind);
        end else begin
          st_d.stat.cal_ignored = 1'b1;  // unknown opcode
        end
      end
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q                   <= '0;
      st_q.stat.pd_mode      <= PD_NONE;
      st_q.stat.cal_kind     <= CAL_NONE;
      st_q.stat.io_buf_en    <= 1'b1;
      st_q.stat.imp_default  <= 1'b1;
      st_q.cal_cnt           <= CNT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign stat_o = st_q.stat;  // straight from the state flops

endmodule : lpzq_core

// ---- core/lpzq_pkg.sv ----
// Purpose: shared types and constants for the power-down and impedance
//          calibration tracker of a low-power DDR memory device.
// Assumes: core clock mclk_i at 25 MHz samples the slower link clock.
// Notes:   calibration periods are module parameters, given in ns.
package lpzq_pkg;

  localparam int          CLK_MHZ     = 25;     // core clock rate
  localparam int          CA_W        = 10;     // command/address width
  localparam int          SYNC_W      = CA_W + 4;
  localparam int          CNT_W       = 20;     // calibration counter width
  localparam logic [7:0]  CAL_MR_ADDR = 8'h0A;  // calibration mode register
  localparam logic [3:0]  MODE_WR_CODE = 4'h0;  // ca[3:0] of a mode write
  localparam logic [CNT_W-1:0] CNT_RST = 20'h00000;

  // power-down classification
  typedef enum logic [1:0] {
    PD_NONE   = 2'b00,
    PD_IDLE   = 2'b01,
    PD_ACTIVE = 2'b10
  } lpzq_pd_t;

  // calibration kind in progress
  typedef enum logic [1:0] {
    CAL_NONE  = 2'b00,
    CAL_INIT  = 2'b01,
    CAL_LONG  = 2'b10,
    CAL_SHORT = 2'b11
  } lpzq_cal_t;

  // pins from the controller side
  typedef struct packed {
    logic            cke;
    logic            cs_n;
    logic [CA_W-1:0] ca;
  } lpzq_pins_t;

  // status shown to the rest of the device
  typedef struct packed {
    lpzq_pd_t  pd_mode;      // power-down state and its class
    logic      io_buf_en;    // input/output buffers enabled
    logic      refresh_hold; // internal refresh suspended
    lpzq_cal_t cal_kind;     // calibration running
    logic      imp_default;  // impedance at default settings
    logic      cal_done;     // one-cycle pulse at end of calibration
    logic      cal_ignored;  // one-cycle pulse: command dropped
  } lpzq_stat_t;

  // whole state of the core
  typedef struct packed {
    logic            ck_prev;
    logic            cke_prev;
    logic            wr_half;    // first half of a mode write seen
    logic [CA_W-1:0] ca_rise;
    logic [CNT_W-1:0] cal_cnt;
    logic            tied;       // reference pin strapped to supply
    logic            tied_valid;
    lpzq_stat_t      stat;
  } lpzq_state_t;

endpackage : lpzq_pkg

// ---- core/lpzq_sync.sv ----
// Purpose: two-stage synchroniser for pins from outside the clock domain.
// Assumes: each bit is sampled independently; skew between bits is
//          absorbed because the link clock is far slower than mclk_i.
// Notes:   stage one feeds stage two only.
module lpzq_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // two flops in series, only the second reads the first
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : lpzq_sync

// ---- tb/lpzq_core_tb.sv ----
// Purpose: self-checking bench for lpzq_core
// Assumes: opcodes are the core's default parameter values
// Notes:   calibration rows are timed against 25/9/3 cycle periods
module lpzq_core_tb
  import lpzq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] op;
    logic       banks;
    logic [2:0] nops;
    lpzq_cal_t  kind;
    logic       dflt;
  } lpzq_row_t;
  logic       mclk_i, reset_i, ref_tied_i, banks_open_i, link_ck_i;
  lpzq_pins_t pins_i;
  lpzq_stat_t stat_o;
  int         num_errors, checks_done;
  // op, open bank, trailing no-ops, kind and default flag afterwards
  lpzq_row_t  rows [10] = '{
    {8'h01, 1'b0, 3'd0, CAL_INIT, 1'b1}, {8'h04, 1'b0, 3'd0, CAL_INIT, 1'b1},
    {8'h02, 1'b0, 3'd4, CAL_NONE, 1'b0}, {8'h04, 1'b0, 3'd0, CAL_NONE, 1'b1},
    {8'h02, 1'b0, 3'd0, CAL_LONG, 1'b1}, {8'h03, 1'b1, 3'd4, CAL_NONE, 1'b0},
    {8'h04, 1'b0, 3'd0, CAL_NONE, 1'b1}, {8'h3C, 1'b0, 3'd0, CAL_NONE, 1'b1},
    {8'h03, 1'b1, 3'd0, CAL_NONE, 1'b1}, {8'h03, 1'b0, 3'd1, CAL_NONE, 1'b0}};
  lpzq_core u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .link_ck_i(link_ck_i),
    .pins_i(pins_i), .ref_tied_i(ref_tied_i), .banks_open_i(banks_open_i),
    .stat_o(stat_o));
  lpzq_ctrl_model u_ctl (.link_ck_o(link_ck_i), .pins_o(pins_i));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // reset with a strap value, then look at the reset state
  task automatic rst(input logic tied);
    @(posedge mclk_i);
    reset_i <= 1'b1;
    ref_tied_i <= tied;
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk({stat_o.pd_mode, stat_o.io_buf_en, stat_o.refresh_hold}, 4'h2);
    chk({1'b0, stat_o.cal_kind, stat_o.imp_default}, 4'h1);
  endtask : rst
  // fixed waits in core cycles; one device, init first
  task automatic cal(input lpzq_row_t r);
    @(posedge mclk_i);
    banks_open_i <= r.banks;
    u_ctl.mode_wr(r.op);
    u_ctl.nop(r.nops);
    // sample between edges, clear of the edge that launches the result
    repeat (4) @(negedge mclk_i);
    chk({1'b0, stat_o.cal_kind, stat_o.imp_default}, {1'b0, r.kind, r.dflt});
  endtask : cal
  // no-op, entry, a frame with enable held low, then exit with select high
  task automatic pd(input logic banks, input logic cs_n, input lpzq_pd_t m);
    @(posedge mclk_i);
    banks_open_i <= banks;
    u_ctl.nop(1);
    u_ctl.cmd(1'b0, cs_n, 10'h3FF, 10'h000);
    u_ctl.cmd(1'b0, 1'b1, 10'h000, 10'h3FF);
    chk({stat_o.pd_mode, stat_o.io_buf_en, stat_o.refresh_hold},
        {m, m == PD_NONE, m != PD_NONE});
    // exit frame carries only a no-op
    u_ctl.cmd(1'b1, 1'b1, 10'h155, 10'h2AA);
    chk({stat_o.pd_mode, stat_o.io_buf_en, stat_o.refresh_hold}, 4'h2);
  endtask : pd
  initial begin
    reset_i = 1'b1;
    ref_tied_i = 1'b0;
    banks_open_i = 1'b0;
    num_errors = 0;
    checks_done = 0;
    rst(1'b0);
    // reset rows follow at once, no quiet time
    foreach (rows[i]) cal(rows[i]);
    pd(1'b0, 1'b1, PD_IDLE);
    pd(1'b1, 1'b1, PD_ACTIVE);
    pd(1'b0, 1'b0, PD_NONE);
    // reset again just after an init write, before its period can run, now with the strap tied
    u_ctl.mode_wr(8'h01);
    rst(1'b1);
    cal({8'h02, 1'b0, 3'd1, CAL_NONE, 1'b1});
    stop_test();
  end
endmodule : lpzq_core_tb

// ---- tb/lpzq_ctrl_model.sv ----
// Purpose: memory controller model driving link clock and pins
// Assumes: one frame per cmd or mode_wr call, n frames per nop(n), 320 ns link period
// Notes:   link clock stands low between frames
module lpzq_ctrl_model
  import lpzq_pkg::*;
(
  output logic       link_ck_o,
  output lpzq_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_ck_o = 1'b0;
    pins_o = '{1'b1, 1'b1, 10'h155};
  end
  // one link cycle; changes sit 10 ns off the core clock edges so the
  // sampling edge never races them
  // no data bus driven at all
  task automatic cmd(input logic cke, input logic cs_n,
                     input logic [9:0] ca_r, input logic [9:0] ca_f);
    #10 pins_o = '{cke, cs_n, ca_r};
    #80 link_ck_o = 1'b1;
    #80 pins_o.ca = ca_f;
    #80 link_ck_o = 1'b0;
    #70;
  endtask : cmd
  task automatic nop(input int n);
    repeat (n) cmd(1'b1, 1'b1, 10'h2AA, 10'h155);
  endtask : nop
  // address bits 5:0 go out on the rise, 7:6 on the fall
  task automatic mode_wr(input logic [7:0] op);
    cmd(1'b1, 1'b0, {CAL_MR_ADDR[5:0], MODE_WR_CODE},
        {op, CAL_MR_ADDR[7:6]});
  endtask : mode_wr
endmodule : lpzq_ctrl_model

// ---- tb/lpzq_monitor.sv ----
// Purpose: port checker for lpzq_core
// Assumes: pins stay steady around each link edge
// Notes:   pin effects reach stat_o three mclk after the edge
module lpzq_monitor
  import lpzq_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       link_ck_i,
  input  wire lpzq_pins_t pins_i,
  input  wire logic       ref_tied_i,
  input  wire logic       banks_open_i,
  input  wire lpzq_stat_t stat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // power-down entry and exit steps
  sequence s_pd_in;
    $past(stat_o.pd_mode) == PD_NONE && stat_o.pd_mode != PD_NONE;
  endsequence
  sequence s_pd_out;
    $past(stat_o.pd_mode) != PD_NONE && stat_o.pd_mode == PD_NONE;
  endsequence
  property p_pd_in;
    s_pd_in |-> !$past(pins_i.cke, 3) && $past(pins_i.cs_n, 3);
  endproperty
  a_pd_in: assert property (p_pd_in)
    else $error("power-down entered without enable low");
  property p_pd_class;
    s_pd_in |-> stat_o.pd_mode == ($past(banks_open_i) ? PD_ACTIVE : PD_IDLE);
  endproperty
  a_pd_class: assert property (p_pd_class)
    else $error("power-down class wrong");
  property p_pd_out;
    s_pd_out |-> $past(pins_i.cke, 3) && $past(pins_i.cs_n, 3);
  endproperty
  a_pd_out: assert property (p_pd_out)
    else $error("power-down left without enable high");
  property p_bufs;
    stat_o.io_buf_en == (stat_o.pd_mode == PD_NONE);
  endproperty
  a_bufs: assert property (p_bufs)
    else $error("buffers not tied to power-down");
  property p_refresh;
    stat_o.refresh_hold == (stat_o.pd_mode != PD_NONE);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("refresh not held in power-down");
  property p_strap;
    ref_tied_i |-> stat_o.cal_kind == CAL_NONE && stat_o.imp_default;
  endproperty
  a_strap: assert property (p_strap)
    else $error("calibration ran with strapped pin");
  property p_idle_cal;
    $rose(stat_o.cal_kind != CAL_NONE) |-> !$past(banks_open_i);
  endproperty
  a_idle_cal: assert property (p_idle_cal)
    else $error("calibration accepted with open bank");
  // end of a period leaves the calibrated setting in use
  property p_cal_end;
    stat_o.cal_done |-> stat_o.cal_kind == CAL_NONE && !stat_o.imp_default;
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("calibration end pulse out of place");
  // a dropped command never starts a period
  property p_ignored;
    stat_o.cal_ignored |-> !$rose(stat_o.cal_kind != CAL_NONE);
  endproperty
  a_ignored: assert property (p_ignored)
    else $error("dropped command started a calibration");
endmodule : lpzq_monitor

bind lpzq_core lpzq_monitor u_mon (
  .mclk_i(mclk_i), .reset_i(reset_i), .link_ck_i(link_ck_i),
  .pins_i(pins_i), .ref_tied_i(ref_tied_i), .banks_open_i(banks_open_i),
  .stat_o(stat_o));
